// file: ep_ctrl.v
// Endpoint transmit/receive control and status with AXI4-Lite access
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ep_ctrl_regs.vh"
// Notes on behaviour
// - auto commit sets loaded on full packet
// - iso bit device only, reads zero host
// - direction bit matters only for shared FIFO
// - DMA request only when enabled; variant picks mode
// - force flip toggles and drops packet
// - host tx toggle write needs enable
// - host rx toggle write needs enable
// - partial packet flag, iso only, write-zero clears
// - writing one clears the toggle
// - device stall sent flag sticky until cleared
// - host stall received flag plus interrupt
// - device stall request answers with STALL
// - in request clears when packet available
// - flush drops packet, self clears
// - device iso data error cleared with packet
// - host error or NAK timeout flag
module ep_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire host_mode,
  input wire shared_fifo,
  input wire tx_fifo_word,
  input wire link_stall_sent,
  input wire link_stall_rcvd,
  input wire link_rx_packet,
  input wire link_rx_error,
  input wire link_rx_partial,
  input wire link_nak_timeout,
  input wire link_tx_ack,
  input wire link_rx_ack,
  output wire tx_packet_loaded,
  output wire endpoint_is_tx,
  output wire iso_mode,
  output wire stall_answer,
  output wire in_request,
  output wire tx_packet_drop,
  output wire rx_fifo_flush,
  output wire dma_request,
  output wire dma_request_variant,
  output wire tx_toggle,
  output wire rx_toggle,
  output wire irq
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  wire [7:0] ev_s;
  ep_sync2 #(.W(8)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({link_rx_ack, link_tx_ack, link_nak_timeout, link_rx_partial,
          link_rx_error, link_rx_packet, link_stall_rcvd, link_stall_sent}),
    .dout(ev_s)
  );
  wire ev_stall_sent = ev_s[0];
  wire ev_stall_rcvd = ev_s[1];
  wire ev_rx_pkt = ev_s[2];
  wire ev_rx_err = ev_s[3];
  wire ev_partial = ev_s[4];
  wire ev_nak = ev_s[5];
  wire ev_tx_ack = ev_s[6];
  wire ev_rx_ack = ev_s[7];

  // --------------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------------
  reg aw_full_q;
  reg [3:0] aw_addr_q;
  reg w_full_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  wire wr_go = aw_full_q && w_full_q;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_full_q <= 1'b0;
      w_data_q <= `RST_WORD;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_tx = wr_go && aw_addr_q == `OFS_TX_CSR;
  wire wr_rx = wr_go && aw_addr_q == `OFS_RX_CSR;
  wire wr_st = wr_go && aw_addr_q == `OFS_IRQ_STATUS;
  wire wr_mk = wr_go && aw_addr_q == `OFS_IRQ_MASK;
  wire [31:0] wd = w_data_q;
  // Byte-lane qualified bit writes
  wire [31:0] wbit = wmask;

  // --------------------------------------------------------------------------
  // Transmit control word
  // --------------------------------------------------------------------------
  reg [31:0] tx_q;
  reg [10:0] fill_q;
  wire [10:0] maxp = tx_q[`TX_MAXP_HI:0];
  wire full_pkt = tx_fifo_word && (fill_q + 11'h001 >= maxp) && maxp != 11'h000;
  wire auto_set = tx_q[`TX_AUTO_COMMIT] && full_pkt;
  wire force_flip = wr_tx && wbit[`TX_FORCE_FLIP] && wd[`TX_FORCE_FLIP];
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_q <= `RST_WORD;
      fill_q <= 11'h000;
    end else begin
      if (wr_tx) begin
        tx_q <= merge(tx_q, wd, wmask);
        // Force-flip and toggle-clear bits are strobes for the toggle cell, not kept in the word
        tx_q[`TX_FORCE_FLIP] <= 1'b0;
        tx_q[`TX_TOG_CLEAR] <= 1'b0;
      end
      // Hardware set wins over a software write of zero
      if (auto_set) begin
        tx_q[`TX_LOADED] <= 1'b1;
      end else if (ev_tx_ack || force_flip) begin
        tx_q[`TX_LOADED] <= 1'b0;
      end
      if (tx_q[`TX_LOADED] || force_flip) begin
        fill_q <= 11'h000;
      end else if (tx_fifo_word) begin
        fill_q <= full_pkt ? 11'h000 : fill_q + 11'h001;
      end
    end
  end
  assign tx_packet_loaded = tx_q[`TX_LOADED];
  assign tx_packet_drop = force_flip;
  assign iso_mode = tx_q[`TX_ISO] && !host_mode;
  assign endpoint_is_tx = shared_fifo ? tx_q[`TX_DIR] : 1'b1;
  // Mode 1 asks whenever enabled, mode 0 only while no packet waits; a shared FIFO asks only
  assign dma_request = tx_q[`TX_DMA_EN] && (tx_q[`TX_DMA_VARIANT] || !tx_packet_loaded)
    && (!shared_fifo || endpoint_is_tx);
  assign dma_request_variant = tx_q[`TX_DMA_VARIANT];

  // --------------------------------------------------------------------------
  // Data toggles
  // --------------------------------------------------------------------------
  wire tx_tog_wr = wr_tx && host_mode && wbit[`TX_TOG_VAL] && wd[`TX_TOG_WEN];
  ep_toggle u_tx_tog (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(wr_tx && wbit[`TX_TOG_CLEAR] && wd[`TX_TOG_CLEAR]),
    .flip(ev_tx_ack || force_flip),
    .wr(tx_tog_wr),
    .wr_val(wd[`TX_TOG_VAL]),
    .tog_q(tx_toggle)
  );
  wire rx_tog_wr = wr_rx && host_mode && wbit[`RX_TOG_VAL] && wd[`RX_TOG_WEN];
  ep_toggle u_rx_tog (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(wr_rx && wbit[`RX_TOG_CLEAR] && wd[`RX_TOG_CLEAR]),
    .flip(ev_rx_ack),
    .wr(rx_tog_wr),
    .wr_val(wd[`RX_TOG_VAL]),
    .tog_q(rx_toggle)
  );

  // --------------------------------------------------------------------------
  // Receive control and status
  // --------------------------------------------------------------------------
  reg rx_tog_wen_q;
  reg partial_q;
  reg stall_flag_q;
  reg stall_req_q;
  reg in_req_q;
  reg flush_q;
  reg err_q;
  reg pkt_q;
  // Write-zero clears and write-one flush, gated by the byte lane
  wire clr_partial = wr_rx && wbit[`RX_PARTIAL] && !wd[`RX_PARTIAL];
  wire clr_stall = wr_rx && wbit[`RX_STALL_FLAG] && !wd[`RX_STALL_FLAG];
  wire clr_err = wr_rx && wbit[`RX_ERR] && !wd[`RX_ERR];
  wire do_flush = wr_rx && wbit[`RX_FLUSH] && wd[`RX_FLUSH];
  // Stall event per role: device reports sent STALL, host a received one
  wire stall_ev = host_mode ? ev_stall_rcvd : (ev_stall_sent && stall_req_q);
  // Host role counts NAK time-outs only on bulk endpoints, so use the raw iso bit
  wire err_ev = host_mode ? (ev_rx_err || (ev_nak && !tx_q[`TX_ISO]))
                          : (ev_rx_err && iso_mode);
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_tog_wen_q <= 1'b0;
      partial_q <= 1'b0;
      stall_flag_q <= 1'b0;
      stall_req_q <= 1'b0;
      in_req_q <= 1'b0;
      flush_q <= 1'b0;
      err_q <= 1'b0;
      pkt_q <= 1'b0;
    end else begin
      if (wr_rx && wbit[`RX_TOG_WEN]) begin
        rx_tog_wen_q <= wd[`RX_TOG_WEN];
      end
      if (wr_rx && wbit[`RX_STALL_REQ]) begin
        stall_req_q <= wd[`RX_STALL_REQ];
      end
      flush_q <= do_flush;
      if (ev_rx_pkt) begin
        pkt_q <= 1'b1;
      end else if (do_flush) begin
        pkt_q <= 1'b0;
      end
      if (ev_partial && tx_q[`TX_ISO]) begin
        partial_q <= 1'b1;
      end else if (clr_partial) begin
        partial_q <= 1'b0;
      end
      if (stall_ev) begin
        stall_flag_q <= 1'b1;
      end else if (clr_stall) begin
        stall_flag_q <= 1'b0;
      end
      if (err_ev) begin
        err_q <= 1'b1;
      end else if (clr_err || (!host_mode && do_flush)) begin
        err_q <= 1'b0;
      end
      // In request drops as soon as a packet becomes available
      if (ev_rx_pkt || pkt_q) begin
        in_req_q <= 1'b0;
      end else if (wr_rx && wbit[`RX_STALL_REQ] && host_mode) begin
        in_req_q <= wd[`RX_STALL_REQ];
      end
    end
  end
  assign stall_answer = !host_mode && stall_req_q;
  assign in_request = host_mode && in_req_q;
  assign rx_fifo_flush = flush_q;

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  reg [`IRQ_WIDTH-1:0] ist_q;
  reg [`IRQ_WIDTH-1:0] imask_q;
  wire [`IRQ_WIDTH-1:0] iev = {ev_rx_pkt, ev_partial && tx_q[`TX_ISO], err_ev, stall_ev};
  wire [`IRQ_WIDTH-1:0] iclr = (wr_st && w_strb_q[0]) ? wd[`IRQ_WIDTH-1:0] : `RST_IRQ;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ist_q <= `RST_IRQ;
      imask_q <= `RST_IRQ;
    end else begin
      ist_q <= (ist_q & ~iclr) | iev;
      if (wr_mk && w_strb_q[0]) begin
        imask_q <= wd[`IRQ_WIDTH-1:0];
      end
    end
  end
  assign irq = |(ist_q & imask_q);

  // --------------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------------
  wire [31:0] tx_rd = {tx_q[31], iso_mode, tx_q[29:26],
                       host_mode ? tx_q[`TX_TOG_WEN] : 1'b0,
                       host_mode ? tx_toggle : 1'b0,
                       tx_q[23], 1'b0, tx_q[21:0]} & 32'hf7bf_ffff;
  wire [31:0] rx_rd = {5'h00, rx_tog_wen_q, host_mode ? rx_toggle : 1'b0,
                       partial_q && tx_q[`TX_ISO], 1'b0, stall_flag_q,
                       host_mode ? in_req_q : stall_req_q, 1'b0,
                       err_q && (host_mode || iso_mode), 2'b00, pkt_q, 16'h0000};
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RST_WORD;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `OFS_TX_CSR: s_axi_rdata <= tx_rd;
        `OFS_RX_CSR: s_axi_rdata <= rx_rd;
        `OFS_IRQ_STATUS: s_axi_rdata <= {28'h0000000, ist_q};
        `OFS_IRQ_MASK: s_axi_rdata <= {28'h0000000, imask_q};
        default: begin
          s_axi_rdata <= `RST_WORD;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ep_ctrl
`default_nettype wire

// file: ep_ctrl_chk.sv
// Bus and role checks bound to the endpoint control block
`timescale 1ns/1ns
`default_nettype none
module ep_ctrl_chk (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire host_mode,
  input wire shared_fifo,
  input wire endpoint_is_tx,
  input wire iso_mode,
  input wire stall_answer,
  input wire in_request,
  input wire tx_packet_drop,
  input wire rx_fifo_flush
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  bad_read_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'b00
      |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("bad read");
  iso_host_a:
    assert property (host_mode |-> !iso_mode) else $error("iso shown in host role");
  dir_fixed_a:
    assert property (!shared_fifo |-> endpoint_is_tx) else $error("direction without shared fifo");
  stall_role_a:
    assert property (host_mode |-> !stall_answer) else $error("stall answer in host role");
  req_role_a:
    assert property (!host_mode |-> !in_request) else $error("in request in device role");
  flush_pulse_a:
    assert property (rx_fifo_flush |=> !rx_fifo_flush) else $error("flush not self clearing");
  drop_pulse_a:
    assert property (tx_packet_drop |=> !tx_packet_drop) else $error("drop pulse too long");
  cover property (rx_fifo_flush);
  cover property (tx_packet_drop);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // ep_ctrl_chk
bind ep_ctrl ep_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .host_mode(host_mode),
  .shared_fifo(shared_fifo), .endpoint_is_tx(endpoint_is_tx), .iso_mode(iso_mode),
  .stall_answer(stall_answer), .in_request(in_request), .tx_packet_drop(tx_packet_drop),
  .rx_fifo_flush(rx_fifo_flush));
`default_nettype wire

// file: ep_ctrl_regs.vh
// Register offsets, field positions and reset values of the endpoint control block
`ifndef EP_CTRL_REGS_VH
`define EP_CTRL_REGS_VH
// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define OFS_TX_CSR 4'h0
`define OFS_RX_CSR 4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK 4'hc
// ----------------------------------------------------------------------------
// Transmit control word fields
// ----------------------------------------------------------------------------
`define TX_AUTO_COMMIT 31
`define TX_ISO 30
`define TX_DIR 29
`define TX_DMA_EN 28
`define TX_FORCE_FLIP 27
`define TX_DMA_VARIANT 26
`define TX_TOG_WEN 25
`define TX_TOG_VAL 24
`define TX_TOG_CLEAR 22
`define TX_LOADED 16
`define TX_MAXP_HI 10
// ----------------------------------------------------------------------------
// Receive control word fields
// ----------------------------------------------------------------------------
`define RX_TOG_WEN 26
`define RX_TOG_VAL 25
`define RX_PARTIAL 24
`define RX_TOG_CLEAR 23
`define RX_STALL_FLAG 22
`define RX_STALL_REQ 21
`define RX_FLUSH 20
`define RX_ERR 19
`define RX_PKT_AVAIL 16
// ----------------------------------------------------------------------------
// Interrupt status bits and reset values
// ----------------------------------------------------------------------------
`define IRQ_STALL 0
`define IRQ_RX_ERR 1
`define IRQ_PARTIAL 2
`define IRQ_RX_PKT 3
`define IRQ_WIDTH 4
`define RST_WORD 32'h0000_0000
`define RST_IRQ 4'h0
`endif

// file: ep_sync2.v
// Two-stage synchroniser for the link-side event inputs
`timescale 1ns/1ns
`default_nettype none
module ep_sync2 #(
  parameter W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
  assign dout = sync_q;
endmodule // ep_sync2
`default_nettype wire

// file: ep_toggle.v
// One endpoint data toggle with clear, flip and guarded write
`timescale 1ns/1ns
`default_nettype none
module ep_toggle (
  input wire aclk,
  input wire aresetn,
  input wire clear,
  input wire flip,
  input wire wr,
  input wire wr_val,
  output reg tog_q
);
  // Clear has top priority so a clear in the same cycle as a write always lands at zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      tog_q <= 1'b0;
    end else if (clear) begin
      tog_q <= 1'b0;
    end else if (wr) begin
      tog_q <= wr_val;
    end else if (flip) begin
      tog_q <= ~tog_q;
    end
  end
endmodule // ep_toggle
`default_nettype wire

// file: link_model.sv
// Far-side event source: stretches each requested link event over HOLD cycles
`timescale 1ns/1ns
`default_nettype none
module link_model #(
  parameter int HOLD = 3
) (
  input wire logic aclk,
  input wire logic [7:0] fire,
  output logic [7:0] ev
);
  // Events cross two synchroniser flops, so a one-cycle pulse could be lost
  int left [8];
  always @(posedge aclk) begin
    for (int i = 0; i < 8; i++) begin
      if (fire[i])
        left[i] <= HOLD;
      else if (left[i] > 0)
        left[i] <= left[i] - 1;
    end
  end
  always_comb begin
    for (int i = 0; i < 8; i++)
      ev[i] = (left[i] > 0);
  end
endmodule // link_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the endpoint control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic host = 0, shared = 0, word = 0, seen_flush = 0, seen_drop = 0, tog;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] fire = 8'h00;
  logic [10:0] mp;
  logic [33:0] exp_q [$];
  int n_fail = 0, n_checks = 0, cyc = 0, seed = 11857;
  wire awready, wready, bvalid, arready, rvalid, loaded, is_tx, iso, stall_ans, in_req;
  wire drop, flush, dma, dma_var, txt, rxt, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] ev;
  always #4 aclk = ~aclk;
  link_model #(.HOLD(3)) u_link (.aclk(aclk), .fire(fire), .ev(ev));
  ep_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .host_mode(host), .shared_fifo(shared), .tx_fifo_word(word), .link_stall_sent(ev[0]),
    .link_stall_rcvd(ev[1]), .link_rx_packet(ev[2]), .link_rx_error(ev[3]),
    .link_rx_partial(ev[4]), .link_nak_timeout(ev[5]), .link_tx_ack(ev[6]),
    .link_rx_ack(ev[7]), .tx_packet_loaded(loaded), .endpoint_is_tx(is_tx), .iso_mode(iso),
    .stall_answer(stall_ans), .in_request(in_req), .tx_packet_drop(drop),
    .rx_fifo_flush(flush), .dma_request(dma), .dma_request_variant(dma_var),
    .tx_toggle(txt), .rx_toggle(rxt), .irq(irq));
  // ----------
  // Tasks
  // ----------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (e !== g) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cb(input string w, input logic e, input logic g);
    chk(w, {33'h0, e}, {33'h0, g});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    @(posedge aclk);
    exp_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    @(posedge aclk);
    exp_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  // Each event is held past the synchroniser, then the flag needs one more cycle
  task automatic ev_fire(input int i);
    @(posedge aclk);
    fire <= 8'h01 << i;
    @(posedge aclk);
    fire <= 8'h00;
    repeat (8) @(posedge aclk);
  endtask
  task automatic push_word();
    @(posedge aclk);
    word <= 1'b1;
    @(posedge aclk);
    word <= 1'b0;
  endtask
  // Results are compared as they appear on the response channels
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (flush) seen_flush <= 1'b1;
    if (drop) seen_drop <= 1'b1;
    if (aresetn && ((bvalid && bready) || (rvalid && rready)))
      chk("bus", exp_q.pop_front(), bvalid ? {bresp, 32'h0} : {rresp, rdata});
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 16; i += 4) rd(i[3:0], 32'h0);
    rd(4'h2, 32'h0, 2'b10);
    wr(4'h6, 32'hffff_ffff, 2'b10);
    cb("dir", 1'b1, is_tx);
    shared <= 1'b1;
    @(posedge aclk);
    cb("dir", 1'b0, is_tx);
    wr(4'h0, 32'h2000_0000);
    cb("dir", 1'b1, is_tx);
    wr(4'h0, 32'h3000_0000);
    cb("dma", 1'b1, dma);
    wr(4'h0, 32'h1400_0000);
    cb("dma variant", 1'b1, dma_var);
    wr(4'h0, 32'h0400_0000);
    cb("dma", 1'b0, dma);
    wr(4'h0, 32'h4000_0000);
    cb("iso", 1'b1, iso);
    host <= 1'b1;
    rd(4'h0, 32'h0);
    tog = $random(seed);
    wr(4'h0, {6'h00, 1'b1, tog, 24'h0});
    cb("tx toggle", tog, txt);
    wr(4'h0, {7'h00, ~tog, 24'h0});
    cb("tx toggle", tog, txt);
    wr(4'h0, 32'h0300_0000);
    wr(4'h0, 32'h0040_0000);
    cb("tx toggle", 1'b0, txt);
    wr(4'h4, 32'h0600_0000);
    wr(4'h4, 32'h0000_0000);
    cb("rx toggle", 1'b1, rxt);
    wr(4'h4, 32'h0080_0000);
    cb("rx toggle", 1'b0, rxt);
    wr(4'h0, 32'h0800_0000);
    cb("drop", 1'b1, seen_drop);
    rd(4'h0, 32'h0100_0000);
    wr(4'hc, 32'h1);
    ev_fire(1);
    cb("irq", 1'b1, irq);
    rd(4'h4, 32'h0040_0000);
    wr(4'h4, 32'h0);
    wr(4'h8, 32'h1);
    cb("irq", 1'b0, irq);
    host <= 1'b0;
    wr(4'h4, 32'h0020_0000);
    cb("stall", 1'b1, stall_ans);
    wr(4'h4, 32'h0);
    cb("stall", 1'b0, stall_ans);
    host <= 1'b1;
    wr(4'h4, 32'h0020_0000);
    cb("in request", 1'b1, in_req);
    ev_fire(2);
    cb("in request", 1'b0, in_req);
    rd(4'h4, 32'h0001_0000);
    wr(4'h4, 32'h0010_0000);
    @(posedge aclk);
    cb("flush", 1'b1, seen_flush);
    rd(4'h4, 32'h0);
    ev_fire(3);
    rd(4'h4, 32'h0008_0000);
    rd(4'h8, 32'h0000_000a);
    wr(4'hc, 32'h2);
    cb("irq", 1'b1, irq);
    wr(4'h8, 32'hf);
    cb("irq", 1'b0, irq);
    aresetn <= 1'b0;
    host <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    mp = 11'd2 + 11'({$random(seed)} % 3);
    wr(4'h0, {21'h100000, mp});
    repeat (mp - 1) push_word();
    repeat (2) @(posedge aclk);
    cb("loaded", 1'b0, loaded);
    push_word();
    repeat (2) @(posedge aclk);
    cb("loaded", 1'b1, loaded);
    wr(4'h4, 32'h0020_0000);
    ev_fire(0);
    rd(4'h4, 32'h0060_0000);
    wr(4'h4, 32'h0000_0000);
    wr(4'h0, 32'h4000_0000);
    for (int i = 2; i < 5; i++) ev_fire(i);
    rd(4'h4, 32'h0109_0000);
    wr(4'h4, 32'h0010_0000);
    rd(4'h4, 32'h0000_0000);
    host <= 1'b1;
    wr(4'h0, 32'h0000_0000);
    ev_fire(5);
    rd(4'h4, 32'h0008_0000);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
